// ==== hdl/snp_pkg.sv ====
// Package of register map, field positions and timing constants for the image programming block.
package snp_pkg;

	// Register offsets on the serial control port register space.
	localparam logic [7:0] OFS_PROG_COUNT = 8'h10;
	localparam logic [7:0] OFS_ADDR_MSB = 8'h12;
	localparam logic [7:0] OFS_IMAGE_REV = 8'h13;
	localparam logic [7:0] OFS_OVERLAY = 8'h14;
	localparam logic [7:0] OFS_CMD_STATUS = 8'hAB;
	localparam logic [7:0] OFS_PTR_HIGH = 8'hAD;
	localparam logic [7:0] OFS_PTR_LOW = 8'hAE;
	localparam logic [7:0] OFS_DATA_WIN = 8'hB0;
	localparam logic [7:0] OFS_UNLOCK = 8'hB4;

	// Field positions.
	localparam int BIT_COMMIT = 6;
	localparam int BIT_BUSY = 2;
	localparam int BIT_ERASE = 1;
	localparam int BIT_PROGRAM = 0;
	localparam int BIT_OVERLAY = 7;

	// Unlock key and relock value.
	localparam logic [7:0] UNLOCK_KEY = 8'hEA;
	localparam logic [7:0] LOCK_VALUE = 8'h00;

	// Image byte positions for the target address field and the revision byte.
	localparam logic [12:0] IMG_ADDR_MSB = 13'h000C;
	localparam logic [12:0] IMG_REV = 13'h000D;

	// Reset values.
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [4:0] RST_ADDR_MSB = 5'h19;

	// Clock rate and nominal programming time.
	localparam longint CLK_HZ = 64'd20000000;
	localparam longint PROG_TIME_MS = 64'd500;
	localparam longint PROG_CYCLES = (PROG_TIME_MS * CLK_HZ) / 64'd1000;

	// One register bus access, as a packed carrier.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} snp_req_t;

endpackage : snp_pkg

// ==== hdl/snp_image_mem.sv ====
// Byte-wide image store used both for the shadow image and for the nonvolatile array.
`timescale 1ns/1ns
`default_nettype none
module snp_image_mem #(
	parameter int AW = 13
) (
	// Clock.
	input wire logic clk,
	// Write port.
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [7:0] wdata,
	// Read port, registered.
	input wire logic [AW-1:0] raddr,
	output logic [7:0] rdata
);

	// Storage; contents are undefined until first written, like a fresh array.
	logic [7:0] mem [0:(1<<AW)-1];

	// Single write, registered read.
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end

endmodule : snp_image_mem
`default_nettype wire

// ==== hdl/snp_prog_ctrl.sv ====
// Controller that fills the shadow image and programs it into the nonvolatile array.
`timescale 1ns/1ns
`default_nettype none
module snp_prog_ctrl #(
	parameter int AW = 13,
	parameter longint PROG_CYCLES = snp_pkg::PROG_CYCLES
) (
	// Clock and power-on reset.
	input wire logic clk,
	input wire logic rst_b,
	// Register access from the serial control port.
	input wire snp_pkg::snp_req_t req,
	output logic [7:0] rdata,
	output logic rvalid,
	// State presented to the rest of the device.
	output logic [4:0] target_addr_msb,
	output logic nv_busy_flag,
	output logic overlay_enable
);

	// Phases of the sequencer. Eight phases fill the three-bit code, so no
	// code is illegal and the case below needs no default branch.
	typedef enum logic [2:0] {
		ST_BOOT_REQ, ST_BOOT_RD, ST_BOOT_CAP, ST_IDLE, ST_COMMIT, ST_PROG_RD, ST_PROG_WR, ST_PROG_WAIT
	} snp_state_t;

	localparam int CW = $clog2(PROG_CYCLES + 1);
	localparam logic [AW-1:0] LAST = {AW{1'b1}};

	snp_state_t state_r; // Sequencer phase.
	logic [AW-1:0] ptr_r; // Shadow image pointer, upper and lower parts.
	logic [AW-1:0] walk_r; // Walk address for commit, program and boot.
	logic [7:0] unlock_r; // Unlock register contents.
	logic [7:0] count_r; // Program count as read back, loaded during the boot load.
	logic [7:0] nv_count_r; // Stored program count; an array cell, so it has no reset.
	logic nv_pend_r; // A finished program awaits the next power-on; no reset.
	logic nv_valid_r; // The array holds a programmed image; no reset.
	logic [7:0] rev_r; // Revision byte in use.
	logic [4:0] addr_msb_r; // Address upper field in use.
	logic overlay_r; // Overlay enable bit.
	logic commit_r; // Commit bit, cleared by hardware when done.
	logic prog_done; // Last cycle of the programming time.
	logic [CW-1:0] wait_r; // Programming time counter.
	logic [7:0] sh_rd; // Shadow image read data.
	logic [7:0] nv_rd; // Nonvolatile array read data.
	logic sh_we; // Shadow image write strobe.
	logic [AW-1:0] sh_wa; // Shadow image write address.
	logic [7:0] sh_wd; // Shadow image write data.
	logic nv_we; // Nonvolatile array write strobe.
	logic [7:0] commit_byte; // Active register value mapped to a walk address.
	logic cmd_hit; // Erase and program requested together with key present.

	// Shadow image memory.
	snp_image_mem #(.AW(AW)) u_shadow (
		.clk(clk),
		.we(sh_we),
		.waddr(sh_wa),
		.wdata(sh_wd),
		.raddr(walk_r),
		.rdata(sh_rd)
	);

	// Nonvolatile array; it keeps contents across power-on resets since it has no reset.
	snp_image_mem #(.AW(AW)) u_nvarray (
		.clk(clk),
		.we(nv_we),
		.waddr(walk_r),
		.wdata(sh_rd),
		.raddr(walk_r),
		.rdata(nv_rd)
	);

	// Active registers map into the image; a commit writes the address field, revision and
	// overlay bytes from their active registers, and zero to every other image byte.
	always_comb begin
		commit_byte = 8'h00;
		if (walk_r == snp_pkg::IMG_ADDR_MSB) begin
			commit_byte = {addr_msb_r, 3'b000};
		end else if (walk_r == snp_pkg::IMG_REV) begin
			commit_byte = rev_r;
		end else if (walk_r == AW'(snp_pkg::OFS_OVERLAY)) begin
			commit_byte = {overlay_r, 7'h00};
		end
	end

	// Shadow write mux: commit walk has priority over the host window, which is
	// refused while the sequencer owns the image.
	always_comb begin
		sh_we = 1'b0;
		sh_wa = ptr_r;
		sh_wd = req.wdata;
		if (state_r == ST_COMMIT) begin
			sh_we = 1'b1;
			sh_wa = walk_r;
			sh_wd = commit_byte;
		end else if (state_r == ST_IDLE && req.wr && req.addr == snp_pkg::OFS_DATA_WIN) begin
			sh_we = 1'b1;
		end
	end

	// Erase plus program in one write, accepted only with the key present.
	// A command without both bits, or without the key, is dropped without a trace.
	assign cmd_hit = (state_r == ST_IDLE) && req.wr && (req.addr == snp_pkg::OFS_CMD_STATUS)
		&& req.wdata[snp_pkg::BIT_ERASE] && req.wdata[snp_pkg::BIT_PROGRAM]
		&& (unlock_r == snp_pkg::UNLOCK_KEY);

	// Copy whole image; the erase is implied because every byte is overwritten.
	assign nv_we = (state_r == ST_PROG_WR);

	// The programming time runs out in this cycle; the image is then complete.
	assign prog_done = (state_r == ST_PROG_WAIT) && (wait_r >= CW'(PROG_CYCLES - 1));

	// Sequencer: boot load, commit walk and programming walk.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= ST_BOOT_REQ;
			walk_r <= '0;
			wait_r <= '0;
		end else begin
			unique case (state_r)
				ST_BOOT_REQ: begin
					walk_r <= AW'(snp_pkg::IMG_ADDR_MSB);
					state_r <= ST_BOOT_RD;
				end
				ST_BOOT_RD: begin
					state_r <= ST_BOOT_CAP;
				end
				ST_BOOT_CAP: begin
					// Fetch the revision byte right after the address field, then the
					// overlay byte, which sits in the image at the overlay register's offset.
					if (walk_r == snp_pkg::IMG_ADDR_MSB) begin
						walk_r <= AW'(snp_pkg::IMG_REV);
						state_r <= ST_BOOT_RD;
					end else if (walk_r == snp_pkg::IMG_REV) begin
						walk_r <= AW'(snp_pkg::OFS_OVERLAY);
						state_r <= ST_BOOT_RD;
					end else begin
						walk_r <= '0;
						state_r <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					// A commit wins over a program request in the same write.
					if (req.wr && req.addr == snp_pkg::OFS_CMD_STATUS
						&& req.wdata[snp_pkg::BIT_COMMIT]) begin
						walk_r <= '0;
						state_r <= ST_COMMIT;
					end else if (cmd_hit) begin
						walk_r <= '0;
						state_r <= ST_PROG_RD;
					end
				end
				ST_COMMIT: begin
					walk_r <= walk_r + 1'b1;
					if (walk_r == LAST) begin
						state_r <= ST_IDLE;
					end
				end
				ST_PROG_RD: begin
					// The shadow read takes a cycle, so each byte costs two cycles.
					state_r <= ST_PROG_WR;
				end
				ST_PROG_WR: begin
					if (walk_r == LAST) begin
						wait_r <= '0;
						state_r <= ST_PROG_WAIT;
					end else begin
						walk_r <= walk_r + 1'b1;
						state_r <= ST_PROG_RD;
					end
				end
				ST_PROG_WAIT: begin
					// Wait the full nominal programming time after the copy.
					wait_r <= wait_r + 1'b1;
					if (wait_r >= CW'(PROG_CYCLES - 1)) begin
						walk_r <= '0;
						state_r <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Fields captured from the stored image at power-on.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			addr_msb_r <= snp_pkg::RST_ADDR_MSB;
			rev_r <= snp_pkg::RST_BYTE;
		end else if (state_r == ST_BOOT_CAP && nv_valid_r == 1'b1) begin
			// A blank array leaves the factory defaults in place.
			if (walk_r == snp_pkg::IMG_ADDR_MSB) begin
				addr_msb_r <= nv_rd[7:3];
			end else if (walk_r == snp_pkg::IMG_REV) begin
				rev_r <= nv_rd;
			end
		end
	end

	// Overlay bit; at power-on it is reloaded from the image when the image has it set.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			overlay_r <= 1'b0;
		end else if (state_r == ST_BOOT_CAP && walk_r == AW'(snp_pkg::OFS_OVERLAY)
			&& nv_valid_r == 1'b1 && nv_rd[snp_pkg::BIT_OVERLAY]) begin
			overlay_r <= 1'b1;
		end else if (state_r == ST_IDLE && req.wr && req.addr == snp_pkg::OFS_OVERLAY) begin
			overlay_r <= req.wdata[snp_pkg::BIT_OVERLAY];
		end
	end

	// Pointer registers. The pointer does not step after a window write, so each
	// byte needs its own pointer setup.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ptr_r <= '0;
		end else if (req.wr && req.addr == snp_pkg::OFS_PTR_HIGH) begin
			ptr_r[AW-1:8] <= req.wdata[AW-9:0];
		end else if (req.wr && req.addr == snp_pkg::OFS_PTR_LOW) begin
			ptr_r[7:0] <= req.wdata;
		end
	end

	// Unlock register; any other value, including zero, relocks.
	// Keeping the whole byte lets a read show exactly what the host last wrote.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			unlock_r <= snp_pkg::LOCK_VALUE;
		end else if (req.wr && req.addr == snp_pkg::OFS_UNLOCK) begin
			unlock_r <= req.wdata;
		end
	end

	// Commit bit reads one during the copy and clears itself at the end.
	// Host writes reach it only in idle, so a busy walk cannot be restarted.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			commit_r <= 1'b0;
		end else begin
			commit_r <= (state_r == ST_COMMIT) && (walk_r != LAST);
			if (state_r == ST_IDLE && req.wr && req.addr == snp_pkg::OFS_CMD_STATUS) begin
				commit_r <= req.wdata[snp_pkg::BIT_COMMIT];
			end
		end
	end

	// Bookkeeping kept in the array itself. These flops stand for nonvolatile cells, so
	// they have no reset and keep their values across power-on. A blank array reads as
	// unknown, which the equality tests below take as unprogrammed.
	always_ff @(posedge clk) begin
		if (prog_done) begin
			nv_pend_r <= 1'b1;
			nv_valid_r <= 1'b1;
			if (nv_valid_r == 1'b1) begin
				nv_count_r <= nv_count_r; // Keep the stored count until the next power-on.
			end else begin
				// The first program of a blank array starts the count from zero.
				nv_count_r <= 8'h00;
			end
		end else if (state_r == ST_BOOT_REQ && nv_pend_r == 1'b1) begin
			// The power-on after a finished program steps the count once.
			nv_count_r <= nv_count_r + 8'h01;
			nv_pend_r <= 1'b0;
		end
	end

	// Program count as read back; it follows the stored count once the boot load runs.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count_r <= snp_pkg::RST_BYTE;
		end else if (state_r == ST_BOOT_CAP && nv_valid_r == 1'b1) begin
			count_r <= nv_count_r;
		end
	end

	// Read data, one cycle after the request; unmapped offsets read zero.
	// Reads change no state, so a host may poll the status byte as often as it likes.
	// The data window reads zero, since the image is write-only from the port.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= 8'h00;
			rvalid <= 1'b0;
		end else begin
			rvalid <= req.rd;
			rdata <= 8'h00;
			if (req.rd) begin
				unique case (req.addr)
					snp_pkg::OFS_PROG_COUNT: rdata <= count_r;
					snp_pkg::OFS_ADDR_MSB: rdata <= {addr_msb_r, 3'b000};
					snp_pkg::OFS_IMAGE_REV: rdata <= rev_r;
					snp_pkg::OFS_OVERLAY: rdata <= {overlay_r, 7'h00};
					snp_pkg::OFS_CMD_STATUS: rdata <= {1'b0, commit_r, 3'b000,
						nv_busy_flag, 2'b00};
					snp_pkg::OFS_PTR_HIGH: rdata <= {3'b000, ptr_r[AW-1:8]};
					snp_pkg::OFS_PTR_LOW: rdata <= ptr_r[7:0];
					snp_pkg::OFS_DATA_WIN: rdata <= 8'h00;
					snp_pkg::OFS_UNLOCK: rdata <= unlock_r;
					default: rdata <= 8'h00;
				endcase
			end
		end
	end

	// Outputs to the device from flops.
	// The busy flag rises in the cycle after the accepted command and falls with the wait.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			nv_busy_flag <= 1'b0;
			target_addr_msb <= snp_pkg::RST_ADDR_MSB;
			overlay_enable <= 1'b0;
		end else begin
			nv_busy_flag <= cmd_hit || state_r == ST_PROG_RD || state_r == ST_PROG_WR
				|| (state_r == ST_PROG_WAIT && wait_r < CW'(PROG_CYCLES - 1));
			target_addr_msb <= addr_msb_r;
			overlay_enable <= overlay_r;
		end
	end

endmodule : snp_prog_ctrl
`default_nettype wire

// ==== dv/snp_prog_ctrl_assertions.sv ====
// Checker of the image programming controller port behaviour.
`timescale 1ns/1ns
`default_nettype none
module snp_prog_ctrl_assertions #(
	parameter int AW = 13,
	parameter longint PROG_CYCLES = 64'd20
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Watched ports.
	input wire snp_pkg::snp_req_t req,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	input wire logic [4:0] target_addr_msb,
	input wire logic nv_busy_flag,
	input wire logic overlay_enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic key_ok_r; // Unlock register holds the key.
	logic [3:0] up_cnt_r; // Cycles since reset, saturating after start-up.
	logic [31:0] busy_cnt_r; // Length of the current busy period.
	// Shadow of the unlock register, so commands can be judged.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) key_ok_r <= 1'b0;
		else if (req.wr && req.addr == snp_pkg::OFS_UNLOCK) key_ok_r <= req.wdata == snp_pkg::UNLOCK_KEY;
	end
	// Start-up counter; the boot load ends well before it saturates.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) up_cnt_r <= 4'h0;
		else if (up_cnt_r != 4'hF) up_cnt_r <= up_cnt_r + 4'h1;
	end
	// Busy length counter; a long count avoids a huge unrolled repetition.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) busy_cnt_r <= 32'h0;
		else busy_cnt_r <= nv_busy_flag ? busy_cnt_r + 32'h1 : 32'h0;
	end
	a_read_answer: assert property (req.rd |=> rvalid ##1 !rvalid)
		else $error("read not answered by a single pulse");
	a_busy_start: assert property ($rose(nv_busy_flag) |->
		$past(req.wr && req.addr == snp_pkg::OFS_CMD_STATUS && req.wdata[1:0] == 2'b11))
		else $error("busy rose without an erase and program write");
	a_busy_locked: assert property ($rose(nv_busy_flag) |-> $past(key_ok_r))
		else $error("programming started while locked");
	a_busy_hold: assert property ($rose(nv_busy_flag) |-> nv_busy_flag[*8])
		else $error("busy dropped too early");
	a_busy_bound: assert property (nv_busy_flag |->
		busy_cnt_r <= 32'((2 << AW) + PROG_CYCLES + 16))
		else $error("busy held too long");
	a_busy_read: assert property (rvalid && $past(req.addr) == snp_pkg::OFS_CMD_STATUS
		|-> rdata[2] == $past(nv_busy_flag)) else $error("busy bit read wrong");
	a_addr_read: assert property (rvalid && $past(req.addr) == snp_pkg::OFS_ADDR_MSB
		|-> rdata == {$past(target_addr_msb), 3'b000}) else $error("address field read wrong");
	a_addr_fixed: assert property (up_cnt_r == 4'hF |-> $stable(target_addr_msb))
		else $error("address field changed after start-up");
	c_prog_start: cover property ($rose(nv_busy_flag));
	c_prog_done: cover property ($fell(nv_busy_flag));
	c_commit_seen: cover property (rvalid && rdata[6]);
endmodule : snp_prog_ctrl_assertions
bind snp_prog_ctrl snp_prog_ctrl_assertions #(.AW(AW), .PROG_CYCLES(PROG_CYCLES)) u_chk (
	.clk(clk), .rst_b(rst_b), .req(req), .rdata(rdata), .rvalid(rvalid),
	.target_addr_msb(target_addr_msb), .nv_busy_flag(nv_busy_flag),
	.overlay_enable(overlay_enable));
`default_nettype wire

// ==== dv/snp_host.sv ====
// Host model that speaks the register access protocol.
`timescale 1ns/1ns
`default_nettype none
module snp_host (
	// Clock.
	input wire logic clk,
	// Request out, answer in.
	output var snp_pkg::snp_req_t req,
	input wire logic [7:0] rdata,
	input wire logic rvalid
);
	initial req = '0;
	// One write pulse; released lines show inverted values, not stale ones.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask : wr
	// One read pulse, then a bounded wait for the answer.
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
		ok = 1'b0;
		d = 8'h00;
		@(negedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~req.wdata};
		@(negedge clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~req.wdata};
		for (int i = 0; i < 4 && !ok; i++) begin
			if (rvalid === 1'b1) begin
				ok = 1'b1;
				d = rdata;
			end else @(negedge clk);
		end
	endtask : rd
endmodule : snp_host
`default_nettype wire

// ==== dv/snp_prog_ctrl_tb.sv ====
// Self-checking bench of the image programming controller.
`timescale 1ns/1ns
`default_nettype none
module snp_prog_ctrl_tb;
	logic clk = 1'b0; // 20 MHz clock.
	logic rst_b = 1'b0; // Power-on reset.
	snp_pkg::snp_req_t req; // Host request.
	logic [7:0] rdata;
	logic rvalid;
	logic [4:0] tam; // Address field in use.
	logic busy;
	logic ovl;
	int n_errors = 0;
	int n_tests = 0;
	always #25 clk = ~clk;
	snp_host u_host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
	// Full-size image with a short programming time keeps the run brief.
	snp_prog_ctrl #(.AW(13), .PROG_CYCLES(20)) u_dut (.clk(clk), .rst_b(rst_b), .req(req),
		.rdata(rdata), .rvalid(rvalid), .target_addr_msb(tam), .nv_busy_flag(busy),
		.overlay_enable(ovl));
	// Compare and count.
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Print the counts and the verdict, then end.
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test
	// Read, mask and compare; a missing answer ends the run.
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
		input string what);
		logic [7:0] d;
		bit ok;
		u_host.rd(a, d, ok);
		if (!ok) begin
			n_errors++;
			stop_test();
		end else begin
			check(what, d & m, e);
		end
	endtask : rd_chk
	// Poll a status bit until clear, with a bounded count.
	task automatic poll(input logic [7:0] m);
		logic [7:0] d;
		bit ok;
		// A program walk takes two cycles per image byte; each poll takes two cycles.
		for (int i = 0; i < 10000; i++) begin
			u_host.rd(snp_pkg::OFS_CMD_STATUS, d, ok);
			if (ok && (d & m) == 8'h00) return;
		end
		n_errors++;
		stop_test();
	endtask : poll
	// Power-on: reset for two cycles, then let the boot load finish.
	task automatic power_on();
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		repeat (12) @(negedge clk);
	endtask : power_on
	// Main sequence.
	initial begin
		power_on();
		check("address default", {3'h0, tam}, {3'h0, snp_pkg::RST_ADDR_MSB});
		u_host.wr(snp_pkg::OFS_CMD_STATUS, 8'h03);
		repeat (2) @(negedge clk);
		check("busy while locked", {7'h0, busy}, 8'h00);
		$display("Test locked command done");
		u_host.wr(snp_pkg::OFS_OVERLAY, 8'h80);
		rd_chk(snp_pkg::OFS_OVERLAY, 8'h80, 8'h80, "overlay bit");
		u_host.wr(snp_pkg::OFS_CMD_STATUS, 8'h40);
		rd_chk(snp_pkg::OFS_CMD_STATUS, 8'h40, 8'h40, "commit running");
		poll(8'h40);
		$display("Test commit done");
		u_host.wr(snp_pkg::OFS_PTR_HIGH, 8'h00);
		u_host.wr(snp_pkg::OFS_PTR_LOW, 8'h0C);
		u_host.wr(snp_pkg::OFS_DATA_WIN, 8'hA8);
		u_host.wr(snp_pkg::OFS_PTR_LOW, 8'h0D);
		u_host.wr(snp_pkg::OFS_DATA_WIN, 8'h5A);
		u_host.wr(snp_pkg::OFS_ADDR_MSB, 8'h00);
		u_host.wr(snp_pkg::OFS_IMAGE_REV, 8'h00);
		u_host.wr(snp_pkg::OFS_UNLOCK, snp_pkg::UNLOCK_KEY);
		u_host.wr(snp_pkg::OFS_CMD_STATUS, 8'h03);
		@(negedge clk);
		check("busy raised", {7'h0, busy}, 8'h01);
		poll(8'h04);
		u_host.wr(snp_pkg::OFS_UNLOCK, snp_pkg::LOCK_VALUE);
		$display("Test programming done");
		power_on();
		check("address in use", {3'h0, tam}, 8'h15);
		check("overlay restored", {7'h0, ovl}, 8'h01);
		rd_chk(snp_pkg::OFS_ADDR_MSB, 8'hFF, 8'hA8, "address field");
		rd_chk(snp_pkg::OFS_IMAGE_REV, 8'hFF, 8'h5A, "revision");
		rd_chk(snp_pkg::OFS_PROG_COUNT, 8'hFF, 8'h01, "program count");
		rd_chk(snp_pkg::OFS_OVERLAY, 8'h80, 8'h80, "overlay reload");
		$display("Test reload done");
		stop_test();
	end
endmodule : snp_prog_ctrl_tb
`default_nettype wire
